// ===== verification/i2c_ctrl_model.sv
// two-wire bus controller model that frames, clocks and can stall the clock
module i2c_ctrl_model (
  output logic      scl,
  output logic      sda,
  input  wire logic dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull_low;
  // open drain with pull-up: a released line reads high, never a stale value
  assign sda = ~(pull_low | dev_oe);
  initial begin
    scl = 1'h1;
    pull_low = 1'h0;
  end
  // start: data falls while the clock is high
  task start_frame;
    // step off the clock edge so the pins never race the sampling flops
    #1;
    pull_low = 1'h1;
    #16 scl = 1'h0;
    pull_low = 1'h0;
  endtask : start_frame
  // link clock runs only inside frames, 32 ns period
  task pulses(input int n);
    #1;
    repeat (n) begin
      #16 scl = 1'h1;
      #16 scl = 1'h0;
    end
  endtask : pulses
  // stop: data rises while the clock is high
  task stop_frame;
    #1;
    pull_low = 1'h1;
    #16 scl = 1'h1;
    #16 pull_low = 1'h0;
  endtask : stop_frame
endmodule : i2c_ctrl_model

// ===== verification/temp_seq_tb.sv
// self-checking bench for the temperature conversion sequencer
`include "temp_seq_consts.svh"
module temp_seq_tb
  import temp_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // counts shortened so the whole run stays near a thousand cycles
  localparam int PWR = 20;
  localparam int CONV = 10;
  localparam int CYC = 400;
  localparam int TMO = 50;
  logic        clk = 1'h0;
  logic        resetn = 1'h0;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready, sda_drive_req;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        sda_out, sda_oe, low_power_halt_state, scl, sda;
  logic [31:0] wdata, rdata, d;
  logic [15:0] adc_sample;
  logic [1:0]  nv_startup_mode, bresp, rresp, resp;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          el;
  time         t0;

  always #2 clk = ~clk;

  temp_seq #(.PWR_CYC(PWR), .CONV_CYC(CONV), .CYCLE_CYC(CYC),
    .TIMEOUT_CYC(TMO)) u_temp_seq (.clk(clk), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .adc_sample(adc_sample),
    .nv_startup_mode(nv_startup_mode), .scl_in(scl), .sda_in(sda),
    .sda_drive_req(sda_drive_req), .sda_out(sda_out), .sda_oe(sda_oe),
    .low_power_halt_state(low_power_halt_state), .irq(irq));

  i2c_ctrl_model u_i2c_ctrl_model (.scl(scl), .sda(sda), .dev_oe(sda_oe));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      final_report;
    end
  end

  // both channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
    @(posedge clk);
  endtask : wr

  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
    @(posedge clk);
  endtask : rd

  // elapsed cycles since t0 once irq is seen high
  task wait_irq(input int max);
    el = 0;
    while (irq !== 1'h1 && el < max) begin
      @(posedge clk);
      el++;
    end
    el = int'(($time - t0) / 4);
  endtask : wait_irq

  task t_powerup;
    t0 = $time;
    rd(`ADDR_RESULT);
    check(d, 32'h0000_8000);
    rd(`ADDR_CONFIG);
    check(d & 32'h0000_003f, 32'h0000_0004);
    wr(`ADDR_IRQ_ENABLE, 32'h0000_0001);
    wait_irq(200);
    check(el >= PWR + 8 * CONV && el <= PWR + 8 * CONV + 12, 1'h1);
    t0 = $time;
    rd(`ADDR_CONFIG);
    check(d[4], 1'h1);
    rd(`ADDR_CONFIG);
    check(d[4], 1'h0);
    rd(`ADDR_RESULT);
    check(d, 32'h0000_f380);
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    check(irq, 1'h0);
    wait_irq(500);
    check(el >= CYC - 2 && el <= CYC + 2, 1'h1);
  endtask : t_powerup

  task t_oneshot;
    wr(`ADDR_CONFIG, 32'h0000_0005);
    repeat (2) @(posedge clk);
    check(low_power_halt_state, 1'h1);
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    t0 = $time;
    wr(`ADDR_CONFIG, 32'h0000_0003);
    wait_irq(100);
    check(el >= CONV && el <= CONV + 8, 1'h1);
    repeat (2) @(posedge clk);
    check(low_power_halt_state, 1'h1);
    rd(`ADDR_CONFIG);
    check(d[1:0], 2'h1);
    adc_sample <= 16'h0c80;
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    t0 = $time;
    wr(`ADDR_CONFIG, 32'h0000_0007);
    // last four of eight samples one step higher: a mean of x.5 rounds up
    repeat (45) @(posedge clk);
    adc_sample <= 16'h0c81;
    wait_irq(200);
    check(el >= 8 * CONV && el <= 8 * CONV + 8, 1'h1);
    rd(`ADDR_RESULT);
    check(d, 32'h0000_0c81);
    rd(`ADDR_IRQ_STATUS);
    check(d[0], 1'h1);
    // mask, unmask and clear the pending done event
    wr(`ADDR_IRQ_ENABLE, 32'h0000_0000);
    check(irq, 1'h0);
    wr(`ADDR_IRQ_ENABLE, 32'h0000_0001);
    check(irq, 1'h1);
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    check(irq, 1'h0);
    t0 = $time;
    wr(`ADDR_CONFIG, 32'h0000_000b);
    wait_irq(400);
    check(el >= 32 * CONV && el <= 32 * CONV + 8, 1'h1);
    rd(`ADDR_RESULT);
    check(d, 32'h0000_0c81);
    wr(`ADDR_CONFIG, 32'h0000_0006);
    repeat (2) @(posedge clk);
    check(low_power_halt_state, 1'h0);
  endtask : t_oneshot

  task t_unmapped;
    rd(8'h14);
    check(resp, `RESP_SLVERR);
    check(d, 32'h0000_0000);
    wr(8'h14, 32'h0000_0001);
    check(resp, `RESP_SLVERR);
    wr(`ADDR_RESULT, 32'h0000_1234);
    check(resp, `RESP_OKAY);
    rd(`ADDR_RESULT);
    check(resp, `RESP_OKAY);
    check(d, 32'h0000_0c81);
  endtask : t_unmapped

  // clock stalls low mid-frame while the device holds data low
  task t_timeout;
    u_i2c_ctrl_model.start_frame;
    @(posedge clk);
    sda_drive_req <= 1'h1;
    u_i2c_ctrl_model.pulses(3);
    @(posedge clk);
    repeat (30) @(posedge clk);
    check(sda_oe, 1'h1);
    check(sda, 1'h0);
    check(sda_out, 1'h0);
    repeat (30) @(posedge clk);
    check(sda_oe, 1'h0);
    check(sda, 1'h1);
    rd(`ADDR_IRQ_STATUS);
    check(d[1], 1'h1);
    sda_drive_req <= 1'h0;
    u_i2c_ctrl_model.stop_frame;
    @(posedge clk);
  endtask : t_timeout

  // stored single-shot start-up falls back to halted
  task t_startup_halt;
    nv_startup_mode <= 2'h3;
    resetn <= 1'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    repeat (PWR + 5) @(posedge clk);
    check(low_power_halt_state, 1'h1);
    repeat (100) @(posedge clk);
    rd(`ADDR_RESULT);
    check(d, 32'h0000_8000);
  endtask : t_startup_halt

  initial begin
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    sda_drive_req = 1'h0;
    adc_sample = 16'hf380;
    nv_startup_mode = 2'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    t_powerup;
    t_oneshot;
    t_unmapped;
    t_timeout;
    t_startup_halt;
    final_report;
  end
endmodule : temp_seq_tb

// ===== verilog/sync2.sv
// two flip-flop synchroniser for one pin
module sync2 (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b1;
      q    <= 1'b1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sync2

// ===== verilog/temp_seq.sv
// conversion sequencer with averaging, bus timeout and axi4-lite registers
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`include "temp_seq_consts.svh"

module temp_seq
  import temp_seq_pkg::*;
#(
  parameter int unsigned PWR_CYC =
    (`T_POWERUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned CONV_CYC =
    (`T_CONV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned CYCLE_CYC =
    (`T_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned TIMEOUT_CYC =
    (`T_BUS_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [15:0] adc_sample,
  input  wire logic [1:0]  nv_startup_mode,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        sda_drive_req,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             low_power_halt_state,
  output logic             irq
);

  seq_state_t         state;
  logic [31:0]        pwr_cnt;
  logic [31:0]        conv_cnt;
  logic [31:0]        cycle_cnt;
  logic [6:0]         sample_cnt;
  logic [6:0]         avg_n;
  logic [2:0]         avg_shift;
  logic [1:0]         conversion_mode_select;
  logic [1:0]         averaging_count_select;
  logic [1:0]         startup_mode;
  logic               startup_taken;
  logic               startup_halt;
  logic               single_shot_conversion;
  logic signed [22:0] acc;
  logic signed [22:0] next_acc;
  logic signed [22:0] rounded;
  logic signed [22:0] half;
  logic [15:0]        mean;
  logic [15:0]        temp_result;
  logic               data_ready;
  logic               first_done;
  logic               pwr_done;
  logic               conv_end;
  logic               publish;
  logic [7:0]         aw_q;
  logic [31:0]        w_q;
  logic [3:0]         wstrb_q;
  logic               wr_fire;
  logic               cfg_wr;
  logic               rd_fire;
  logic               rd_clear;
  logic [31:0]        next_rdata;
  logic               rd_ok;
  logic               wr_ok;
  logic [1:0]         irq_status;
  logic [1:0]         irq_enable;
  logic [1:0]         irq_events;
  logic               scl_s;
  logic               sda_s;
  logic               scl_d;
  logic               sda_d;
  logic               bus_start;
  logic               bus_stop;
  logic               in_xfer;
  logic               released;
  logic [31:0]        idle_cnt;
  logic               bus_timeout;

  // averaging count and divide shift; only code 01 is pinned to eight
  always_comb begin
    case (averaging_count_select)
      2'h0: begin
        avg_n     = 7'd1;
        avg_shift = 3'd0;
      end
      2'h1: begin
        avg_n     = 7'd8;
        avg_shift = 3'd3;
      end
      2'h2: begin
        avg_n     = 7'd32;
        avg_shift = 3'd5;
      end
      default: begin
        avg_n     = 7'd64;
        avg_shift = 3'd6;
      end
    endcase
  end

  // wide signed sum, then divide by power of two with half-up rounding
  always_comb begin
    next_acc = acc + {{7{adc_sample[15]}}, adc_sample};
    half     = (avg_shift == 3'd0) ? 23'sd0
             : 23'(signed'(24'sd1 <<< (avg_shift - 3'd1)));
    rounded  = (next_acc + half) >>> avg_shift;
    mean     = rounded[15:0];
  end

  assign single_shot_conversion = conversion_mode_select == `MODE_ONESHOT;
  assign startup_halt = startup_mode == `MODE_HALT
                     || startup_mode == `MODE_ONESHOT;
  assign pwr_done = state == ST_POWERUP && pwr_cnt == PWR_CYC - 1;
  assign conv_end = state == ST_CONVERT && conv_cnt == CONV_CYC - 1
                 && conversion_mode_select != `MODE_HALT;
  assign publish  = conv_end && sample_cnt >= avg_n - 7'd1;

  // start-up setting taken in the first cycle after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startup_taken <= 1'b0;
      startup_mode  <= `MODE_CONT_A;
    end else if (!startup_taken) begin
      startup_taken <= 1'b1;
      startup_mode  <= nv_startup_mode;
    end
  end

  // configuration: software write wins over hardware updates
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conversion_mode_select <= `MODE_CONT_A;
      averaging_count_select <= `AVG_FACTORY;
    end else if (cfg_wr) begin
      conversion_mode_select <= w_q[1:0];
      averaging_count_select <= w_q[3:2];
    end else if (pwr_done) begin
      conversion_mode_select <= startup_halt ? `MODE_HALT
                              : startup_mode;
    end else if (publish && single_shot_conversion) begin
      conversion_mode_select <= `MODE_HALT;
    end
  end

  // conversion sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state      <= ST_POWERUP;
      pwr_cnt    <= 32'h0000_0000;
      conv_cnt   <= 32'h0000_0000;
      cycle_cnt  <= 32'h0000_0000;
      sample_cnt <= 7'd0;
      acc        <= 23'sd0;
    end else begin
      case (state)
        ST_POWERUP: begin
          if (pwr_done) begin
            state <= startup_halt ? ST_HALT : ST_CONVERT;
          end else begin
            pwr_cnt <= pwr_cnt + 32'h0000_0001;
          end
        end
        ST_CONVERT: begin
          cycle_cnt <= cycle_cnt + 32'h0000_0001;
          if (conversion_mode_select == `MODE_HALT) begin
            state      <= ST_HALT;
            conv_cnt   <= 32'h0000_0000;
            sample_cnt <= 7'd0;
            acc        <= 23'sd0;
          end else if (publish) begin
            conv_cnt   <= 32'h0000_0000;
            sample_cnt <= 7'd0;
            acc        <= 23'sd0;
            if (single_shot_conversion) begin
              state <= ST_HALT;
            end else if (cycle_cnt >= CYCLE_CYC - 1) begin
              cycle_cnt <= 32'h0000_0000;
            end else begin
              state <= ST_STANDBY;
            end
          end else if (conv_end) begin
            conv_cnt   <= 32'h0000_0000;
            sample_cnt <= sample_cnt + 7'd1;
            acc        <= next_acc;
          end else begin
            conv_cnt <= conv_cnt + 32'h0000_0001;
          end
        end
        ST_STANDBY: begin
          cycle_cnt <= cycle_cnt + 32'h0000_0001;
          if (conversion_mode_select == `MODE_HALT) begin
            state <= ST_HALT;
          end else if (single_shot_conversion
                       || cycle_cnt >= CYCLE_CYC - 1) begin
            state     <= ST_CONVERT;
            cycle_cnt <= 32'h0000_0000;
          end
        end
        ST_HALT: begin
          if (conversion_mode_select != `MODE_HALT) begin
            state     <= ST_CONVERT;
            cycle_cnt <= 32'h0000_0000;
            conv_cnt  <= 32'h0000_0000;
          end
        end
        default: begin
          state <= ST_HALT;
        end
      endcase
    end
  end

  // published result and done flag; a new result beats a clearing read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      temp_result <= `RESULT_RESET;
      first_done  <= 1'b0;
      data_ready  <= 1'b0;
    end else begin
      if (publish) begin
        temp_result <= mean;
        first_done  <= 1'b1;
        data_ready  <= 1'b1;
      end else if (rd_clear) begin
        data_ready  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_power_halt_state <= 1'b0;
    end else begin
      low_power_halt_state <= state == ST_HALT;
    end
  end

  // bus pins cross into clk before anything looks at them
  sync2 u_sync_scl (
    .clk    (clk),
    .resetn (resetn),
    .d      (scl_in),
    .q      (scl_s)
  );

  sync2 u_sync_sda (
    .clk    (clk),
    .resetn (resetn),
    .d      (sda_in),
    .q      (sda_s)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign bus_start   = scl_s && sda_d && !sda_s;
  assign bus_stop    = scl_s && !sda_d && sda_s;
  assign bus_timeout = in_xfer && !bus_start && !bus_stop
                    && scl_s == scl_d && idle_cnt == TIMEOUT_CYC - 1;

  // stall watchdog: freed line stays freed until the next start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_xfer  <= 1'b0;
      released <= 1'b0;
      idle_cnt <= 32'h0000_0000;
    end else if (bus_start) begin
      in_xfer  <= 1'b1;
      released <= 1'b0;
      idle_cnt <= 32'h0000_0000;
    end else if (bus_stop) begin
      in_xfer  <= 1'b0;
      idle_cnt <= 32'h0000_0000;
    end else if (in_xfer) begin
      if (scl_s != scl_d) begin
        idle_cnt <= 32'h0000_0000;
      end else if (bus_timeout) begin
        released <= 1'b1;
        in_xfer  <= 1'b0;
        idle_cnt <= 32'h0000_0000;
      end else begin
        idle_cnt <= idle_cnt + 32'h0000_0001;
      end
    end
  end

  // open-drain data line: only ever pulls low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= sda_drive_req && !released && !bus_timeout;
    end
  end

  // interrupts: sticky status, set wins over clear
  assign irq_events = {bus_timeout, publish};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= 2'h0;
      irq_enable <= 2'h0;
      irq        <= 1'b0;
    end else begin
      if (wr_fire && aw_q == `ADDR_IRQ_CLEAR && wstrb_q[0]) begin
        irq_status <= (irq_status & ~w_q[1:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
      if (wr_fire && aw_q == `ADDR_IRQ_ENABLE && wstrb_q[0]) begin
        irq_enable <= w_q[1:0];
      end
      irq <= |(irq_status & irq_enable);
    end
  end

  // axi4-lite write: address and data taken in either order
  assign wr_fire = !awready && !wready && !bvalid;
  assign cfg_wr  = wr_fire && aw_q == `ADDR_CONFIG && wstrb_q[0];
  assign wr_ok   = aw_q == `ADDR_CONFIG || aw_q == `ADDR_IRQ_CLEAR
                || aw_q == `ADDR_IRQ_ENABLE || aw_q == `ADDR_RESULT
                || aw_q == `ADDR_IRQ_STATUS;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      aw_q    <= 8'h00;
      w_q     <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_q    <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_q     <= wdata;
        wstrb_q <= wstrb;
        wready  <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // axi4-lite read; reading config or result clears the done flag
  assign rd_fire  = arvalid && arready;
  assign rd_clear = rd_fire
                 && (araddr == `ADDR_CONFIG || araddr == `ADDR_RESULT);

  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_ok      = 1'b1;
    case (araddr)
      `ADDR_CONFIG: begin
        next_rdata[5:0] = {low_power_halt_state, data_ready,
                           averaging_count_select, conversion_mode_select};
      end
      `ADDR_RESULT: begin
        next_rdata[15:0] = temp_result;
      end
      `ADDR_IRQ_STATUS: begin
        next_rdata[1:0] = irq_status;
      end
      `ADDR_IRQ_CLEAR: begin
        next_rdata = 32'h0000_0000;
      end
      `ADDR_IRQ_ENABLE: begin
        next_rdata[1:0] = irq_enable;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else if (rd_fire) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= next_rdata;
      rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_powerup_wait;
    ($past(state) == ST_POWERUP && state != ST_POWERUP)
      |-> $past(pwr_cnt) == PWR_CYC - 1;
  endproperty
  a_powerup_wait: assert property (p_powerup_wait)
    else $error("conversion began before power-up wait ended");

  property p_startup_choice;
    ($past(state) == ST_POWERUP && state != ST_POWERUP)
      |-> (state == ST_HALT) == startup_halt;
  endproperty
  a_startup_choice: assert property (p_startup_choice)
    else $error("start-up mode not honoured");

  property p_result_reset;
    !first_done |-> temp_result == `RESULT_RESET;
  endproperty
  a_result_reset: assert property (p_result_reset)
    else $error("result not at reset code before first conversion");

  sequence s_last_sample;
    conv_end && sample_cnt >= avg_n - 7'd1;
  endsequence

  sequence s_published;
    data_ready && first_done && acc == 23'sd0 && sample_cnt == 7'd0;
  endsequence

  property p_publish_mean;
    s_last_sample |=> s_published and temp_result == $past(mean);
  endproperty
  a_publish_mean: assert property (p_publish_mean)
    else $error("mean not published after last conversion");

  property p_eight_avg;
    (publish && averaging_count_select == 2'h1) |-> sample_cnt == 7'd7;
  endproperty
  a_eight_avg: assert property (p_eight_avg)
    else $error("group of eight did not hold eight conversions");

  property p_no_mid_update;
    (state == ST_CONVERT && !conv_end
     && conversion_mode_select != `MODE_HALT)
      |=> acc == $past(acc) && temp_result == $past(temp_result);
  endproperty
  a_no_mid_update: assert property (p_no_mid_update)
    else $error("sum changed inside one conversion");

  property p_drdy_clear;
    (rd_clear && !publish) |=> !data_ready;
  endproperty
  a_drdy_clear: assert property (p_drdy_clear)
    else $error("done flag survived a clearing read");

  property p_abort;
    ((state == ST_CONVERT || state == ST_STANDBY)
     && conversion_mode_select == `MODE_HALT) |=> state == ST_HALT;
  endproperty
  a_abort: assert property (p_abort)
    else $error("halt mode did not abort");

  property p_oneshot_halt;
    (publish && single_shot_conversion && !cfg_wr)
      |=> state == ST_HALT && conversion_mode_select == `MODE_HALT;
  endproperty
  a_oneshot_halt: assert property (p_oneshot_halt)
    else $error("single conversion did not return to halt");

  property p_release;
    bus_timeout |=> !sda_oe && released;
  endproperty
  a_release: assert property (p_release)
    else $error("data line held after bus timeout");

endmodule : temp_seq

// ===== verilog/temp_seq_consts.svh
// constants of the temperature conversion sequencer
`ifndef TEMP_SEQ_CONSTS_SVH
`define TEMP_SEQ_CONSTS_SVH
// Summary of operation
// - when the bus clock stalls in a transaction, data line is freed in 20-40 ms.
// - after reset ends, no conversion starts before 1.5 ms have passed.
// - a stored start-up setting can make the device start halted.
// - the result reads as -256 degrees until the first conversion ends.
// - averaging select 01 builds each result from eight conversions.
// - conversions are summed and only the mean is published, once per group.
// - active time is the averaging count times one 15.5 ms conversion.
// - factory settings average eight conversions on a one second cycle.
// - averaging applies in continuous and in single-shot operation.
// - the result is 16-bit two's complement at 7.8125 m-degrees per step.
// - mode 00 and 10 run continuously, 01 aborts and halts, 11 runs once.
// - after a single conversion the device halts with no standby period.
// - each published result sets a done flag, cleared by reading config
//   or result.

`define CLK_PERIOD_NS      4
`define T_POWERUP_NS       1500000
`define T_CONV_NS          15500000
`define T_CYCLE_NS         1000000000
`define T_BUS_TIMEOUT_NS   20000000

`define ADDR_CONFIG        8'h00
`define ADDR_RESULT        8'h04
`define ADDR_IRQ_STATUS    8'h08
`define ADDR_IRQ_CLEAR     8'h0C
`define ADDR_IRQ_ENABLE    8'h10

`define MODE_CONT_A        2'h0
`define MODE_HALT          2'h1
`define MODE_CONT_B        2'h2
`define MODE_ONESHOT       2'h3
`define AVG_FACTORY        2'h1
`define RESULT_RESET       16'h8000

`define IRQ_DONE_BIT       0
`define IRQ_TIMEOUT_BIT    1
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// ===== verilog/temp_seq_pkg.sv
// types of the temperature conversion sequencer
package temp_seq_pkg;
  typedef enum logic [3:0] {
    ST_POWERUP = 4'h1,
    ST_CONVERT = 4'h2,
    ST_STANDBY = 4'h4,
    ST_HALT    = 4'h8
  } seq_state_t;
endpackage : temp_seq_pkg
